/* File: inc/scsu_cfg.svh */
// Constants of the system control and status unit
`ifndef SCSU_CFG_SVH
`define SCSU_CFG_SVH
`define SCSU_CLK_HZ 200000000
`define SCSU_FLASH_MS 75
`define SCSU_CHECK_MS 20
`define SCSU_SLEEP_LSB_MS 500
`define SCSU_SAMPLE_DHZ 8192
`define SCSU_DRDY_US 60
`define SCSU_A_FWC 7'h00
`define SCSU_A_MISC 7'h38
`define SCSU_A_SLEEP 7'h3e
`define SCSU_A_DIAG 7'h40
`define SCSU_A_GCMD 7'h42
`define SCSU_A_LOTLO 7'h52
`define SCSU_A_LOTHI 7'h54
`define SCSU_A_PART 7'h56
`define SCSU_A_SERIAL 7'h58
`define SCSU_CMD_SWRST 7
`define SCSU_CMD_FLASH 3
`define SCSU_CMD_DAC 2
`define SCSU_CMD_CAL 1
`define SCSU_CMD_BIAS 0
`define SCSU_CMD_MASK 8'h8f
`define SCSU_MISC_LO_MASK 8'hc7
`define SCSU_MISC_SUM 11
`define SCSU_MISC_ST 10
`define SCSU_MISC_DREN 2
`define SCSU_MISC_DRPOL 1
`define SCSU_MISC_DRSEL 0
`define SCSU_MISC_LINC 7
`define SCSU_MISC_POP 6
`define SCSU_MISC_RST 16'h0006
`define SCSU_DIAG_RST 16'h0000
`define SCSU_D_LOW 0
`define SCSU_D_HIGH 1
`define SCSU_D_FLASH 2
`define SCSU_D_SPI 3
`define SCSU_D_OVR 4
`define SCSU_D_ST 5
`define SCSU_D_SUM 6
`define SCSU_D_ALM1 8
`define SCSU_D_ALM2 9
`define SCSU_D_AXIS 10
`endif

/* File: inc/scsu_pkg.sv */
// Types of the system control and status unit
package scsu_pkg;
  typedef enum logic [5:0] {
    st_boot = 6'h01,
    st_run = 6'h02,
    st_flash = 6'h04,
    st_cal = 6'h08,
    st_test = 6'h10,
    st_sleep = 6'h20
  } scsu_state_type;
endpackage

/* File: verilog/scsu_spi_slave.sv */
// Serial port slave, mode 3, 16-bit frames
`timescale 1ns/1ps
`default_nettype none
module scsu_spi_slave (
  input wire logic clk, // System clock
  input wire logic arst_n, // Async reset
  input wire logic sclk, // Serial clock pin
  input wire logic cs_n, // Chip select pin
  input wire logic mosi, // Serial data in pin
  input wire logic [15:0] tx_word, // Word for the next frame
  output logic miso, // Serial data out
  output logic miso_oe, // Data out enable
  output logic frm_vld, // Frame received pulse
  output logic [15:0] frm_word, // Received frame
  output logic frm_err, // Clock count error pulse
  output logic cs_fall // Chip select fall pulse
);
  logic [2:0] sclk_ff, nxt_sclk, cs_ff, nxt_cs;
  logic [1:0] mosi_ff, nxt_mosi;
  logic [3:0] cnt_ff, nxt_cnt;
  logic [15:0] rx_ff, nxt_rx, tx_ff, nxt_tx, frm_ff, nxt_frm;
  logic vld_ff, nxt_vld, err_ff, nxt_err, fall_ff, nxt_fall, oe_ff, nxt_oe;
  logic rise, sfall, act;

  always_comb
  begin
    nxt_sclk = {sclk_ff[1:0], sclk};
    nxt_cs = {cs_ff[1:0], cs_n};
    nxt_mosi = {mosi_ff[0], mosi};
    rise = sclk_ff[1] & ~sclk_ff[2];
    sfall = ~sclk_ff[1] & sclk_ff[2];
    act = ~cs_ff[1];
    nxt_cnt = cnt_ff;
    nxt_rx = rx_ff;
    nxt_tx = tx_ff;
    nxt_frm = frm_ff;
    nxt_vld = 1'b0;
    nxt_fall = act & cs_ff[2];
    nxt_err = ~act & ~cs_ff[2] & (cnt_ff != 4'h0);
    nxt_oe = act;
    if (nxt_fall)
      nxt_cnt = 4'h0;
    else if (act & rise)
    begin
      nxt_cnt = cnt_ff + 4'h1;
      nxt_rx = {rx_ff[14:0], mosi_ff[1]};
      if (cnt_ff == 4'hf)
      begin
        nxt_vld = 1'b1;
        nxt_frm = {rx_ff[14:0], mosi_ff[1]};
      end
    end
    // First falling edge of each frame loads the answer word
    if (act & sfall)
      nxt_tx = (cnt_ff == 4'h0) ? tx_word : {tx_ff[14:0], 1'b0};
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sclk_ff <= 3'h7;
      cs_ff <= 3'h7;
      mosi_ff <= 2'h0;
      cnt_ff <= 4'h0;
      rx_ff <= 16'h0;
      tx_ff <= 16'h0;
      frm_ff <= 16'h0;
      vld_ff <= 1'b0;
      err_ff <= 1'b0;
      fall_ff <= 1'b0;
      oe_ff <= 1'b0;
    end
    else
    begin
      sclk_ff <= nxt_sclk;
      cs_ff <= nxt_cs;
      mosi_ff <= nxt_mosi;
      cnt_ff <= nxt_cnt;
      rx_ff <= nxt_rx;
      tx_ff <= nxt_tx;
      frm_ff <= nxt_frm;
      vld_ff <= nxt_vld;
      err_ff <= nxt_err;
      fall_ff <= nxt_fall;
      oe_ff <= nxt_oe;
    end
  end

  assign miso = tx_ff[15];
  assign miso_oe = oe_ff;
  assign frm_vld = vld_ff;
  assign frm_word = frm_ff;
  assign frm_err = err_ff;
  assign cs_fall = fall_ff;
endmodule
`default_nettype wire

/* File: verilog/scsu_top.sv */
// System control and status unit with serial register access
`timescale 1ns/1ps
`default_nettype none
`include "scsu_cfg.svh"
module scsu_top #(
  parameter int unsigned FLASH_CYC = `SCSU_FLASH_MS * (`SCSU_CLK_HZ / 1000),
  parameter int unsigned CHECK_CYC = `SCSU_CHECK_MS * (`SCSU_CLK_HZ / 1000),
  parameter int unsigned HALF_SEC_CYC = `SCSU_SLEEP_LSB_MS * (`SCSU_CLK_HZ / 1000),
  parameter int unsigned SAMPLE_CYC = (`SCSU_CLK_HZ * 10) / `SCSU_SAMPLE_DHZ,
  parameter int unsigned DRDY_CYC = `SCSU_DRDY_US * (`SCSU_CLK_HZ / 1000000),
  parameter int unsigned SELFTEST_CYC = 4096,
  parameter int unsigned BOOT_CYC = 16,
  parameter int unsigned CAL_CYC = 64,
  parameter logic [15:0] LOT_LO = 16'h0001, // Arbitrary value
  parameter logic [15:0] LOT_HI = 16'h0002, // Arbitrary value
  parameter logic [15:0] PART_ID = 16'h1234, // Arbitrary value
  parameter logic [11:0] SERIAL = 12'h001 // Arbitrary value
) (
  input wire logic clk, // System clock
  input wire logic arst_n, // Async reset, power cycle
  input wire logic sclk, // Serial clock pin
  input wire logic cs_n, // Chip select pin
  input wire logic mosi, // Serial data in pin
  output logic miso, // Serial data out pin
  output logic miso_oe, // Data out enable
  input wire logic ext_rst_n, // Reset pin
  input wire logic supply_low, // Supply below range
  input wire logic supply_high, // Supply above range
  input wire logic overrange, // Sensor overrange
  input wire logic alarm1, // Alarm one active
  input wire logic alarm2, // Alarm two active
  input wire logic flash_fail, // Flash write failed
  input wire logic sum_mismatch, // Program sum differs
  input wire logic [5:0] axis_fail, // Per-axis self test fail
  output logic sampling_en, // Sampling running
  output logic dac_latch, // DAC latch pulse
  output logic cal_restore, // Calibration restore pulse
  output logic bias_correct, // Bias correction pulse
  output logic flash_write, // Flash written pulse
  output logic selftest_run, // Self test active
  output logic gyro_lin_comp, // Gyro acceleration compensation
  output logic perc_align, // Percussion alignment
  output logic io_line_one, // Data ready on line one
  output logic io_line_one_oe, // Line one drive enable
  output logic io_line_two, // Data ready on line two
  output logic io_line_two_oe // Line two drive enable
);
  import scsu_pkg::*;

  // ----------------------------------------
  // Serial port and register decode
  // ----------------------------------------
  logic frm_vld, frm_err, cs_fall;
  logic [15:0] frm_word, rd_ff, nxt_rd;
  logic [6:0] adr, adr_even;
  logic [7:0] dat;
  logic wr_en, rd_hit, rd_diag;
  scsu_state_type state_ff, nxt_state;

  scsu_spi_slave u_spi (
    .clk(clk),
    .arst_n(arst_n),
    .sclk(sclk),
    .cs_n(cs_n),
    .mosi(mosi),
    .tx_word(rd_ff),
    .miso(miso),
    .miso_oe(miso_oe),
    .frm_vld(frm_vld),
    .frm_word(frm_word),
    .frm_err(frm_err),
    .cs_fall(cs_fall)
  );

  assign adr = frm_word[14:8];
  assign adr_even = {adr[6:1], 1'b0};
  assign dat = frm_word[7:0];
  assign wr_en = frm_vld & frm_word[15] & (state_ff == st_run);
  assign rd_hit = frm_vld & ~frm_word[15];
  assign rd_diag = rd_hit & (adr_even == `SCSU_A_DIAG);

  // ----------------------------------------
  // Reset pin synchroniser
  // ----------------------------------------
  logic [2:0] xrst_ff, nxt_xrst;
  logic rst_fall;
  assign nxt_xrst = {xrst_ff[1:0], ext_rst_n};
  assign rst_fall = ~xrst_ff[1] & xrst_ff[2];

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      xrst_ff <= 3'h7;
    else
      xrst_ff <= nxt_xrst;
  end

  // ----------------------------------------
  // Control sequencer
  // ----------------------------------------
  logic [39:0] tmr_ff, nxt_tmr;
  logic [7:0] cmd_ff, nxt_cmd;
  logic [15:0] misc_ff, nxt_misc, bak_ff, nxt_bak, fwc_ff, nxt_fwc;
  logic timed_ff, nxt_timed, sumsel_ff, nxt_sumsel, smp_ff, nxt_smp;
  logic dac_ff, nxt_dac, cal_ff, nxt_cal, bias_ff, nxt_bias, fwr_ff, nxt_fwr;
  logic tmr_done, fl_end, test_end;

  assign tmr_done = (tmr_ff == 40'h0);
  assign fl_end = (state_ff == st_flash) & tmr_done;
  assign test_end = (state_ff == st_test) & tmr_done;

  always_comb
  begin
    nxt_state = state_ff;
    nxt_tmr = tmr_done ? tmr_ff : tmr_ff - 40'h1;
    nxt_cmd = cmd_ff;
    nxt_misc = misc_ff;
    nxt_bak = bak_ff;
    nxt_fwc = fwc_ff;
    nxt_timed = timed_ff;
    nxt_sumsel = sumsel_ff;
    nxt_dac = 1'b0;
    nxt_cal = 1'b0;
    nxt_bias = 1'b0;
    nxt_fwr = 1'b0;
    unique case (state_ff)
      st_boot:
        if (tmr_done)
        begin
          nxt_state = st_run;
          nxt_misc = bak_ff;
          nxt_cmd = 8'h00;
        end
      st_run:
      begin
        if (cmd_ff[`SCSU_CMD_DAC])
        begin
          nxt_dac = 1'b1;
          nxt_cmd[`SCSU_CMD_DAC] = 1'b0;
        end
        if (cmd_ff[`SCSU_CMD_SWRST])
        begin
          nxt_state = st_boot;
          nxt_tmr = 40'(BOOT_CYC - 1);
        end
        else if (cmd_ff[`SCSU_CMD_CAL] | cmd_ff[`SCSU_CMD_BIAS])
        begin
          nxt_state = st_cal;
          nxt_tmr = 40'(CAL_CYC - 1);
          nxt_cal = cmd_ff[`SCSU_CMD_CAL];
          nxt_bias = cmd_ff[`SCSU_CMD_BIAS];
        end
        else if (cmd_ff[`SCSU_CMD_FLASH])
        begin
          nxt_state = st_flash;
          nxt_tmr = 40'(FLASH_CYC - 1);
        end
        else if (misc_ff[`SCSU_MISC_SUM])
        begin
          nxt_state = st_test;
          nxt_tmr = 40'(CHECK_CYC - 1);
          nxt_sumsel = 1'b1;
        end
        else if (misc_ff[`SCSU_MISC_ST])
        begin
          nxt_state = st_test;
          nxt_tmr = 40'(SELFTEST_CYC - 1);
          nxt_sumsel = 1'b0;
        end
        if (wr_en)
        begin
          unique case (adr)
            `SCSU_A_MISC:
              nxt_misc[7:0] = dat & `SCSU_MISC_LO_MASK;
            `SCSU_A_MISC + 7'h01:
            begin
              nxt_misc[11:10] = dat[3:2];
              nxt_misc[9:8] = 2'b00;
            end
            `SCSU_A_GCMD:
              nxt_cmd = nxt_cmd | (dat & `SCSU_CMD_MASK);
            `SCSU_A_SLEEP:
              if (dat != 8'h00)
              begin
                nxt_state = st_sleep;
                nxt_timed = 1'b1;
                nxt_tmr = 40'(dat) * 40'(HALF_SEC_CYC) - 40'h1;
              end
            `SCSU_A_SLEEP + 7'h01:
              if (dat[0])
              begin
                nxt_state = st_sleep;
                nxt_timed = 1'b0;
              end
            default:
              nxt_state = nxt_state;
          endcase
        end
      end
      st_cal:
        if (tmr_done)
        begin
          nxt_state = st_flash;
          nxt_tmr = 40'(FLASH_CYC - 1);
        end
      st_flash:
        if (tmr_done)
        begin
          nxt_state = st_run;
          nxt_bak = misc_ff & 16'hf3ff;
          nxt_fwc = fwc_ff + 16'h1;
          nxt_fwr = 1'b1;
          nxt_cmd[`SCSU_CMD_FLASH] = 1'b0;
          nxt_cmd[`SCSU_CMD_CAL] = 1'b0;
          nxt_cmd[`SCSU_CMD_BIAS] = 1'b0;
        end
      st_test:
        if (tmr_done)
        begin
          nxt_state = st_run;
          if (sumsel_ff)
            nxt_misc[`SCSU_MISC_SUM] = 1'b0;
          else
            nxt_misc[`SCSU_MISC_ST] = 1'b0;
        end
      st_sleep:
        if (cs_fall | rst_fall | (timed_ff & tmr_done))
          nxt_state = st_run;
      default:
        nxt_state = st_boot;
    endcase
    nxt_smp = (nxt_state == st_run);
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_ff <= st_boot;
      tmr_ff <= 40'(BOOT_CYC - 1);
      cmd_ff <= 8'h00;
      misc_ff <= `SCSU_MISC_RST;
      bak_ff <= `SCSU_MISC_RST;
      fwc_ff <= 16'h0000;
      timed_ff <= 1'b0;
      sumsel_ff <= 1'b0;
      smp_ff <= 1'b0;
      dac_ff <= 1'b0;
      cal_ff <= 1'b0;
      bias_ff <= 1'b0;
      fwr_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      tmr_ff <= nxt_tmr;
      cmd_ff <= nxt_cmd;
      misc_ff <= nxt_misc;
      bak_ff <= nxt_bak;
      fwc_ff <= nxt_fwc;
      timed_ff <= nxt_timed;
      sumsel_ff <= nxt_sumsel;
      smp_ff <= nxt_smp;
      dac_ff <= nxt_dac;
      cal_ff <= nxt_cal;
      bias_ff <= nxt_bias;
      fwr_ff <= nxt_fwr;
    end
  end

  assign sampling_en = smp_ff;
  assign dac_latch = dac_ff;
  assign cal_restore = cal_ff;
  assign bias_correct = bias_ff;
  assign flash_write = fwr_ff;

  // ----------------------------------------
  // Sample tick and data ready
  // ----------------------------------------
  logic [31:0] sc_ff, nxt_sc, dc_ff, nxt_dc;
  logic act_ff, nxt_act, io1_ff, nxt_io1, oe1_ff, nxt_oe1, io2_ff, nxt_io2, oe2_ff, nxt_oe2;
  logic st_ff, nxt_st, lc_ff, nxt_lc, pa_ff, nxt_pa;
  logic tick, dr_lvl;

  assign tick = (state_ff == st_run) & (sc_ff == 32'h0);

  always_comb
  begin
    nxt_sc = (tick | (state_ff != st_run)) ? 32'(SAMPLE_CYC - 1) : sc_ff - 32'h1;
    nxt_dc = (dc_ff == 32'h0) ? dc_ff : dc_ff - 32'h1;
    nxt_act = (dc_ff == 32'h0) ? 1'b0 : act_ff;
    if (tick & misc_ff[`SCSU_MISC_DREN])
    begin
      nxt_dc = 32'(DRDY_CYC - 1);
      nxt_act = 1'b1;
    end
    dr_lvl = misc_ff[`SCSU_MISC_DRPOL] ? act_ff : ~act_ff;
    nxt_oe1 = misc_ff[`SCSU_MISC_DREN] & ~misc_ff[`SCSU_MISC_DRSEL];
    nxt_oe2 = misc_ff[`SCSU_MISC_DREN] & misc_ff[`SCSU_MISC_DRSEL];
    nxt_io1 = nxt_oe1 & dr_lvl;
    nxt_io2 = nxt_oe2 & dr_lvl;
    nxt_st = (nxt_state == st_test) & ~nxt_sumsel;
    nxt_lc = misc_ff[`SCSU_MISC_LINC];
    nxt_pa = misc_ff[`SCSU_MISC_POP];
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sc_ff <= 32'h0;
      dc_ff <= 32'h0;
      act_ff <= 1'b0;
      io1_ff <= 1'b0;
      oe1_ff <= 1'b0;
      io2_ff <= 1'b0;
      oe2_ff <= 1'b0;
      st_ff <= 1'b0;
      lc_ff <= 1'b0;
      pa_ff <= 1'b0;
    end
    else
    begin
      sc_ff <= nxt_sc;
      dc_ff <= nxt_dc;
      act_ff <= nxt_act;
      io1_ff <= nxt_io1;
      oe1_ff <= nxt_oe1;
      io2_ff <= nxt_io2;
      oe2_ff <= nxt_oe2;
      st_ff <= nxt_st;
      lc_ff <= nxt_lc;
      pa_ff <= nxt_pa;
    end
  end

  assign io_line_one = io1_ff;
  assign io_line_one_oe = oe1_ff;
  assign io_line_two = io2_ff;
  assign io_line_two_oe = oe2_ff;
  assign selftest_run = st_ff;
  assign gyro_lin_comp = lc_ff;
  assign perc_align = pa_ff;

  // ----------------------------------------
  // Diagnostic flags and read data
  // ----------------------------------------
  logic [15:0] diag_ff, nxt_diag;

  always_comb
  begin
    nxt_diag = rd_diag ? 16'h0000 : diag_ff;
    if (tick)
    begin
      nxt_diag[`SCSU_D_LOW] = supply_low;
      nxt_diag[`SCSU_D_HIGH] = nxt_diag[`SCSU_D_HIGH] | supply_high;
      nxt_diag[`SCSU_D_OVR] = nxt_diag[`SCSU_D_OVR] | overrange;
      nxt_diag[`SCSU_D_ALM1] = nxt_diag[`SCSU_D_ALM1] | alarm1;
      nxt_diag[`SCSU_D_ALM2] = nxt_diag[`SCSU_D_ALM2] | alarm2;
    end
    if (frm_err)
      nxt_diag[`SCSU_D_SPI] = 1'b1;
    if (fl_end & flash_fail)
      nxt_diag[`SCSU_D_FLASH] = 1'b1;
    if (test_end & sumsel_ff & sum_mismatch)
      nxt_diag[`SCSU_D_SUM] = 1'b1;
    if (test_end & ~sumsel_ff & (axis_fail != 6'h00))
    begin
      nxt_diag[`SCSU_D_ST] = 1'b1;
      nxt_diag[15:10] = nxt_diag[15:10] | axis_fail;
    end
    nxt_rd = rd_ff;
    if (rd_hit)
    begin
      unique case (adr_even)
        `SCSU_A_FWC: nxt_rd = fwc_ff;
        `SCSU_A_MISC: nxt_rd = misc_ff;
        `SCSU_A_DIAG: nxt_rd = diag_ff;
        `SCSU_A_LOTLO: nxt_rd = LOT_LO;
        `SCSU_A_LOTHI: nxt_rd = LOT_HI;
        `SCSU_A_PART: nxt_rd = PART_ID;
        `SCSU_A_SERIAL: nxt_rd = {4'h0, SERIAL};
        default: nxt_rd = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      diag_ff <= `SCSU_DIAG_RST;
      rd_ff <= 16'h0000;
    end
    else
    begin
      diag_ff <= nxt_diag;
      rd_ff <= nxt_rd;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  property p_dac;
    (state_ff == st_run) && cmd_ff[2] |=> dac_latch && !cmd_ff[2];
  endproperty
  a_dac: assert property (p_dac) else $error("DAC latch not issued");

  property p_swrst;
    (state_ff == st_run) && cmd_ff[7] |=> (state_ff == st_boot) && !sampling_en;
  endproperty
  a_swrst: assert property (p_swrst) else $error("Soft reset not taken");

  property p_boot;
    (state_ff == st_boot) && tmr_done |=> (misc_ff == $past(bak_ff)) && cmd_ff == 8'h00;
  endproperty
  a_boot: assert property (p_boot) else $error("Boot reload wrong");

  property p_fcnt;
    fl_end |=> (fwc_ff == $past(fwc_ff) + 16'h1) && flash_write && !cmd_ff[3];
  endproperty
  a_fcnt: assert property (p_fcnt) else $error("Flash count wrong");

  property p_cal;
    (state_ff == st_cal) && tmr_done |=> (state_ff == st_flash);
  endproperty
  a_cal: assert property (p_cal) else $error("No flash after calibration");

  property p_wake;
    (state_ff == st_sleep) && (cs_fall || rst_fall) |=> state_ff == st_run ##1 sampling_en;
  endproperty
  a_wake: assert property (p_wake) else $error("No wake");

  property p_timed;
    wr_en && adr == `SCSU_A_SLEEP && dat != 8'h00
      |=> state_ff == st_sleep && tmr_ff == 40'($past(dat)) * 40'(HALF_SEC_CYC) - 40'h1;
  endproperty
  a_timed: assert property (p_timed) else $error("Timed sleep length wrong");

  property p_rdclr;
    rd_diag && !tick && !frm_err && !fl_end && !test_end |=> diag_ff == 16'h0000;
  endproperty
  a_rdclr: assert property (p_rdclr) else $error("Flags not cleared on read");

  property p_spierr;
    frm_err |=> diag_ff[3];
  endproperty
  a_spierr: assert property (p_spierr) else $error("Transfer error not flagged");

  property p_sum;
    test_end && sumsel_ff |=> !misc_ff[11] && (diag_ff[6] || !$past(sum_mismatch));
  endproperty
  a_sum: assert property (p_sum) else $error("Checksum end wrong");

  property p_sleepq;
    (state_ff == st_sleep) |-> !tick ##1 !sampling_en || state_ff == st_run;
  endproperty
  a_sleepq: assert property (p_sleepq) else $error("Sampling during sleep");

  c_boot: cover property ((state_ff == st_boot) ##1 (state_ff == st_run));
  c_sleep: cover property ((state_ff == st_sleep) && timed_ff && tmr_done);
  c_sum: cover property (test_end && sumsel_ff);
  c_rd: cover property (rd_diag && diag_ff != 16'h0000);
endmodule
`default_nettype wire

/* File: testbench/scsu_host_model.sv */
// Host serial master model for register access
`timescale 1ns/1ps
`default_nettype none
module scsu_host_model #(
  parameter int HALF = 6
) (
  input wire logic clk, // System clock
  output logic sclk, // Serial clock, idles high
  output logic cs_n, // Chip select
  output logic mosi, // Serial data out
  input wire logic miso // Serial data in
);
  initial
  begin
    sclk = 1'h1;
    cs_n = 1'h1;
    mosi = 1'h1;
  end
  // Frame of n clocks, MSB first; rd holds the previous frame's answer
  task automatic xfer(input logic [15:0] w, input int n, output logic [15:0] rd);
    rd = 16'h0000;
    @(posedge clk);
    cs_n <= 1'h0;
    for (int i = 0; i < n; i++)
    begin
      repeat (HALF) @(posedge clk);
      sclk <= 1'h0;
      mosi <= w[15 - i];
      repeat (HALF) @(posedge clk);
      sclk <= 1'h1;
      rd[15 - i] = miso;
    end
    repeat (HALF) @(posedge clk);
    cs_n <= 1'h1;
    mosi <= ~mosi;
    repeat (HALF) @(posedge clk);
  endtask
endmodule
`default_nettype wire

/* File: testbench/test_system_control_status_unit.sv */
// Testbench of the system control and status unit
`timescale 1ns/1ps
`default_nettype none
module test_system_control_status_unit;
  logic clk = 1'h0;
  logic arst_n = 1'h0;
  logic ext_rst_n = 1'h1;
  logic sup_lo = 1'h0, sup_hi = 1'h0, al1 = 1'h0, ffail = 1'h0, smis = 1'h0;
  logic ovr = 1'h0, al2 = 1'h0, st, samp_q = 1'h0, l2_q = 1'h0;
  logic [5:0] axis = 6'h00;
  logic sclk, cs_n, mosi, miso, miso_oe, samp, dac, cal, bias, fw, glc, pa;
  logic l1, l1oe, l2, l2oe;
  logic [15:0] d;
  int mismatches = 0, samples_checked = 0;
  int n_dac = 0, n_cal = 0, n_bias = 0, n_fall = 0;
  int n_fw = 0, n_st = 0, n_l2 = 0;
  always #2.5 clk = ~clk;
  scsu_top #(.FLASH_CYC(40), .CHECK_CYC(30), .HALF_SEC_CYC(20), .SAMPLE_CYC(50),
    .DRDY_CYC(5)) u_dut (
    .clk(clk), .arst_n(arst_n), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso),
    .miso_oe(miso_oe), .ext_rst_n(ext_rst_n), .supply_low(sup_lo), .supply_high(sup_hi),
    .overrange(ovr), .alarm1(al1), .alarm2(al2), .flash_fail(ffail),
    .sum_mismatch(smis), .axis_fail(axis), .sampling_en(samp), .dac_latch(dac),
    .cal_restore(cal), .bias_correct(bias), .flash_write(fw), .selftest_run(st),
    .gyro_lin_comp(glc), .perc_align(pa), .io_line_one(l1), .io_line_one_oe(l1oe),
    .io_line_two(l2), .io_line_two_oe(l2oe));
  scsu_host_model u_host (.clk(clk), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso));
  // Pulse, edge and active-cycle counters, pulses may land inside a frame
  always @(posedge clk)
  begin
    n_dac <= n_dac + int'(dac);
    n_cal <= n_cal + int'(cal);
    n_bias <= n_bias + int'(bias);
    n_fall <= n_fall + int'(samp_q & ~samp);
    n_fw <= n_fw + int'(fw);
    n_st <= n_st + int'(st);
    n_l2 <= n_l2 + int'(l2_q & ~l2);
    samp_q <= samp;
    l2_q <= l2;
  end
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr(input logic [15:0] w);
    u_host.xfer(w, 16, d);
  endtask
  task automatic rd(input logic [6:0] a, output logic [15:0] v);
    u_host.xfer({1'h0, a, 8'h00}, 16, v);
    u_host.xfer(16'h0000, 16, v);
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_ident;
    rd(7'h56, d);
    chk("part", 16'h1234, d);
    rd(7'h52, d);
    chk("lot_lo", 16'h0001, d);
    rd(7'h55, d);
    chk("lot_hi", 16'h0002, d);
    rd(7'h58, d);
    chk("serial", 16'h0001, d);
    rd(7'h00, d);
    chk("fwc", 16'h0000, d);
    rd(7'h38, d);
    chk("misc", 16'h0006, d);
    $display("t_ident done");
  endtask
  task automatic t_cmd;
    wr(16'hc204);
    cyc(10);
    chk("dac", 16'h0001, 16'(n_dac));
    rd(7'h42, d);
    chk("cmd", 16'h0000, d);
    wr(16'hb8c6);
    ffail <= 1'h1;
    wr(16'hc208);
    cyc(60);
    ffail <= 1'h0;
    rd(7'h00, d);
    chk("fwc", 16'h0001, d);
    wr(16'hc201);
    cyc(120);
    wr(16'hc202);
    cyc(120);
    rd(7'h00, d);
    chk("fwc", 16'h0003, d);
    chk("fw", 16'h0003, 16'(n_fw));
    chk("bias", 16'h0001, 16'(n_bias));
    chk("cal", 16'h0001, 16'(n_cal));
    $display("t_cmd done");
  endtask
  task automatic t_reset;
    int f0;
    f0 = n_fall;
    wr(16'hb806);
    wr(16'hc280);
    cyc(40);
    chk("falls", 16'(f0 + 1), 16'(n_fall));
    rd(7'h38, d);
    chk("misc", 16'h00c6, d);
    chk("comp", 16'h0003, {14'h0000, glc, pa});
    $display("t_reset done");
  endtask
  task automatic t_misc;
    wr(16'hb802);
    cyc(10);
    chk("l1oe", 16'h0000, 16'(l1oe));
    chk("l1", 16'h0000, 16'(l1));
    chk("miso_oe", 16'h0000, 16'(miso_oe));
    chk("comp", 16'h0000, {14'h0000, glc, pa});
    wr(16'hb805);
    cyc(60);
    chk("l2oe", 16'h0001, 16'(l2oe));
    chk("l2 pulse", 16'h0001, 16'(n_l2 != 0));
    $display("t_misc done");
  endtask
  task automatic t_check;
    smis <= 1'h1;
    axis <= 6'h04;
    wr(16'hb908);
    cyc(60);
    wr(16'hb904);
    cyc(4110);
    chk("strun", 16'h1000, 16'(n_st));
    rd(7'h38, d);
    chk("misc", 16'h0005, d);
    rd(7'h40, d);
    chk("diag", 16'h1064, d);
    $display("t_check done");
  endtask
  task automatic t_diag;
    sup_lo <= 1'h1;
    sup_hi <= 1'h1;
    al1 <= 1'h1;
    al2 <= 1'h1;
    ovr <= 1'h1;
    cyc(120);
    rd(7'h40, d);
    chk("diag", 16'h0313, d);
    cyc(120);
    rd(7'h40, d);
    chk("diag", 16'h0313, d);
    sup_lo <= 1'h0;
    sup_hi <= 1'h0;
    al1 <= 1'h0;
    al2 <= 1'h0;
    ovr <= 1'h0;
    cyc(120);
    rd(7'h40, d);
    chk("diag", 16'h0312, d);
    u_host.xfer(16'hffff, 8, d);
    rd(7'h40, d);
    chk("diag", 16'h0008, d);
    $display("t_diag done");
  endtask
  task automatic t_sleep;
    wr(16'hbf01);
    cyc(20);
    chk("samp", 16'h0000, 16'(samp));
    wr(16'h0000);
    cyc(40);
    chk("samp", 16'h0001, 16'(samp));
    wr(16'hbe02);
    cyc(20);
    chk("samp", 16'h0000, 16'(samp));
    cyc(60);
    chk("samp", 16'h0001, 16'(samp));
    wr(16'hbf01);
    cyc(20);
    ext_rst_n <= 1'h0;
    cyc(40);
    chk("samp", 16'h0001, 16'(samp));
    ext_rst_n <= 1'h1;
    $display("t_sleep done");
  endtask
  initial
  begin
    #200000;
    mismatches++;
    end_sim();
  end
  initial
  begin
    cyc(4);
    arst_n <= 1'h1;
    cyc(30);
    t_ident();
    t_cmd();
    t_reset();
    t_misc();
    t_check();
    t_diag();
    t_sleep();
    end_sim();
  end
endmodule
`default_nettype wire
